// ### rre_consts.svh
// Encoding constants and field positions for the return and rotate execution block.
`ifndef RRE_CONSTS_SVH
`define RRE_CONSTS_SVH
`define RRE_OP_W            14
`define RRE_ROT_HI          13
`define RRE_ROT_LO          8
`define RRE_ROT_LEFT_PAT    6'h0D
`define RRE_ROT_RIGHT_PAT   6'h0C
`define RRE_DEST_BIT        7
`define RRE_FADDR_HI        6
`define RRE_LIT_HI          7
`define RRE_LIT_HI_OP       13
`define RRE_LIT_LO_OP       8
`define RRE_LIT_PAT         6'h34
`define RRE_IRQ_RET_OP      14'h0009
`define RRE_SUB_RET_OP      14'h0008
`define RRE_GIE_BIT         7
`define RRE_RET_CYCLES      2
`define RRE_ZERO8           8'h00
`define RRE_DATA_W          8
`define RRE_MSB             7
`define RRE_LSB             0
`define RRE_PC_W_MIN        1
`define RRE_PC_W_MAX        16
`endif

// ### rre_pkg.sv
// Types shared by the return and rotate execution block.
package rre_pkg;
    typedef enum logic [2:0] {
        RRE_NONE,
        RRE_IRQ_RET,
        RRE_LIT_RET,
        RRE_SUB_RET,
        RRE_ROT_L,
        RRE_ROT_R
    } rre_op_t;

    typedef struct packed {
        rre_op_t    op;
        logic       dest_file;
        logic [6:0] faddr;
        logic [7:0] literal;
    } rre_dec_t;
endpackage

// ### rre_decode.sv
// Combinational opcode classifier for the return and rotate slice.
`timescale 1ns/100ps
`include "rre_consts.svh"
module rre_decode
    import rre_pkg::*;
(
    // Instruction word
    input  wire logic [13:0] instr_i,
    // Decoded fields
    output rre_dec_t         dec_o
);
    always_comb begin
        dec_o.op        = RRE_NONE;
        dec_o.dest_file = instr_i[`RRE_DEST_BIT];
        dec_o.faddr     = instr_i[`RRE_FADDR_HI:0];
        dec_o.literal   = instr_i[`RRE_LIT_HI:0];
        if (instr_i == `RRE_IRQ_RET_OP) begin
            dec_o.op = RRE_IRQ_RET;
        end else if (instr_i == `RRE_SUB_RET_OP) begin
            dec_o.op = RRE_SUB_RET;
        end else if (instr_i[`RRE_LIT_HI_OP:`RRE_LIT_LO_OP] == `RRE_LIT_PAT) begin
            dec_o.op = RRE_LIT_RET;
        end else if (instr_i[`RRE_ROT_HI:`RRE_ROT_LO] == `RRE_ROT_LEFT_PAT) begin
            dec_o.op = RRE_ROT_L;
        end else if (instr_i[`RRE_ROT_HI:`RRE_ROT_LO] == `RRE_ROT_RIGHT_PAT) begin
            dec_o.op = RRE_ROT_R;
        end
    end
endmodule

// ### rre_exec.sv
// Execution unit for the interrupt, literal and subroutine returns and the two rotates through carry.
// What this block does
// - An interrupt return pops the stack into the program counter, one word, two cycles.
// - An interrupt return sets the global interrupt enable at bit 7 of the interrupt control register, no flags change.
// - A literal return loads the accumulator with its 8-bit literal and the program counter from the stack top in two cycles.
// - A subroutine return pops the stack into the program counter in two cycles, no flags change.
// - Rotate left moves bit n to n+1, bit 7 to carry and old carry to bit 0, only carry changes.
// - The destination bit sends a rotate result to the accumulator when 0 and to the file register when 1.
// - Rotate left is recognised by the pattern 0011 01 d fffffff and takes one cycle.
// - Rotate right moves bit n to n-1, bit 0 to carry and old carry to bit 7, only carry changes.
// - Rotate right uses the same destination select as rotate left.
`timescale 1ns/100ps
`include "rre_consts.svh"
module rre_exec
    import rre_pkg::*;
#(
    parameter int PC_W = 15
)
(
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    // Instruction issue
    input  wire logic            issue_i,
    input  wire logic [13:0]     instr_i,
    output logic                 ready_o,
    output logic                 busy_o,
    // Stack and program counter
    input  wire logic [PC_W-1:0] stack_top_entry_i,
    output logic                 stack_pop_o,
    output logic                 pc_load_o,
    output logic [PC_W-1:0]      program_counter_o,
    // Accumulator and carry
    input  wire logic [7:0]      acc_i,
    input  wire logic            carry_i,
    output logic                 acc_we_o,
    output logic [7:0]           acc_o,
    output logic                 carry_we_o,
    output logic                 carry_o,
    // File register port
    output logic [6:0]           file_addr_o,
    input  wire logic [7:0]      file_rdata_i,
    output logic                 file_we_o,
    output logic [7:0]           file_wdata_o,
    // Interrupt control register
    input  wire logic [7:0]      irq_control_reg_i,
    output logic                 irq_ctl_we_o,
    output logic [7:0]           irq_control_reg_o
);

    // The stack hands over at most sixteen address bits, so a wider counter could never be filled.
    if (PC_W < `RRE_PC_W_MIN || PC_W > `RRE_PC_W_MAX) begin : g_pc_w_check
        $error("PC_W out of range");
    end

    // Only a return needs a second cycle; every other opcode finishes at the edge that takes it.
    typedef enum logic [1:0] {
        RRE_IDLE,
        RRE_RET2
    } rre_state_t;

    rre_dec_t            dec;
    rre_state_t          state_ff,      nxt_state;
    logic                stack_pop_ff,  nxt_stack_pop;
    logic                pc_load_ff,    nxt_pc_load;
    logic [PC_W-1:0]     pc_ff,         nxt_pc;
    logic                acc_we_ff,     nxt_acc_we;
    logic [7:0]          acc_ff,        nxt_acc;
    logic                carry_we_ff,   nxt_carry_we;
    logic                carry_ff,      nxt_carry;
    logic                file_we_ff,    nxt_file_we;
    logic [7:0]          file_wd_ff,    nxt_file_wd;
    logic                irq_we_ff,     nxt_irq_we;
    logic [7:0]          irq_ff,        nxt_irq;
    logic [7:0]          rot_res;
    logic                rot_carry;
    wire logic [7:0]     rol_bits;
    wire logic [7:0]     ror_bits;

    // The decoder holds no state, so every field follows instr_i within the issue cycle.
    rre_decode u_decode (
        .instr_i (instr_i),
        .dec_o   (dec)
    );

    // The file address is presented combinationally so the read data is valid in the issue cycle.
    assign file_addr_o = dec.faddr;
    // A return refuses any issue in its second cycle; the core must hold the next opcode until ready_o.
    assign ready_o     = (state_ff == RRE_IDLE);
    assign busy_o      = (state_ff != RRE_IDLE);

    // Both rotations are built from the file read data at once; the opcode only picks one.
    for (genvar gi = 0; gi < `RRE_DATA_W - 1; gi++) begin : g_rot_bits
        assign rol_bits[gi + 1] = file_rdata_i[gi];
        assign ror_bits[gi]     = file_rdata_i[gi + 1];
    end
    assign rol_bits[`RRE_LSB] = carry_i;
    assign ror_bits[`RRE_MSB] = carry_i;

    // Carry comes from carry_i as it stands in the issue cycle, so the core must forward a carry
    // that this unit wrote one cycle earlier when rotates run back to back.
    always_comb begin
        rot_res   = file_rdata_i;
        rot_carry = carry_i;
        if (dec.op == RRE_ROT_L) begin
            rot_res   = rol_bits;
            rot_carry = file_rdata_i[`RRE_MSB];
        end else if (dec.op == RRE_ROT_R) begin
            rot_res   = ror_bits;
            rot_carry = file_rdata_i[`RRE_LSB];
        end
    end

    // Data registers hold their last value; only the write pulses fall back to zero each cycle.
    always_comb begin
        nxt_state     = state_ff;
        nxt_stack_pop = 1'b0;
        nxt_pc_load   = 1'b0;
        nxt_pc        = pc_ff;
        nxt_acc_we    = 1'b0;
        nxt_acc       = acc_ff;
        nxt_carry_we  = 1'b0;
        nxt_carry     = carry_ff;
        nxt_file_we   = 1'b0;
        nxt_file_wd   = file_wd_ff;
        nxt_irq_we    = 1'b0;
        nxt_irq       = irq_ff;
        unique case (state_ff)
            RRE_IDLE: begin
                if (issue_i) begin
                    unique case (dec.op)
                        RRE_IRQ_RET, RRE_SUB_RET, RRE_LIT_RET: begin
                            // Returns flush the prefetch, so a second dead cycle follows the pop.
                            nxt_state     = RRE_RET2;
                            nxt_stack_pop = 1'b1;
                            nxt_pc_load   = 1'b1;
                            nxt_pc        = stack_top_entry_i;
                            // Only the enable bit is forced; the other control bits go back as they were read.
                            if (dec.op == RRE_IRQ_RET) begin
                                nxt_irq_we = 1'b1;
                                nxt_irq    = irq_control_reg_i | (8'h01 << `RRE_GIE_BIT);
                            end
                            // The literal reaches the accumulator in the same cycle as the pop.
                            if (dec.op == RRE_LIT_RET) begin
                                nxt_acc_we = 1'b1;
                                nxt_acc    = dec.literal;
                            end
                        end
                        // A rotate writes exactly one destination, never both.
                        RRE_ROT_L, RRE_ROT_R: begin
                            nxt_carry_we = 1'b1;
                            nxt_carry    = rot_carry;
                            if (dec.dest_file) begin
                                nxt_file_we = 1'b1;
                                nxt_file_wd = rot_res;
                            end else begin
                                nxt_acc_we = 1'b1;
                                nxt_acc    = rot_res;
                            end
                        end
                        RRE_NONE: begin
                            // Opcodes outside this slice are taken and dropped with no port effect.
                        end
                    endcase
                end
            end
            RRE_RET2: begin
                nxt_state = RRE_IDLE;
            end
            default: begin
                nxt_state = RRE_IDLE;
            end
        endcase
    end

    // Reset clears every write pulse, so the core sees no stray write while it leaves reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff     <= RRE_IDLE;
            stack_pop_ff <= 1'b0;
            pc_load_ff   <= 1'b0;
            pc_ff        <= '0;
            acc_we_ff    <= 1'b0;
            acc_ff       <= `RRE_ZERO8;
            carry_we_ff  <= 1'b0;
            carry_ff     <= 1'b0;
            file_we_ff   <= 1'b0;
            file_wd_ff   <= `RRE_ZERO8;
            irq_we_ff    <= 1'b0;
            irq_ff       <= `RRE_ZERO8;
        end else begin
            state_ff     <= nxt_state;
            stack_pop_ff <= nxt_stack_pop;
            pc_load_ff   <= nxt_pc_load;
            pc_ff        <= nxt_pc;
            acc_we_ff    <= nxt_acc_we;
            acc_ff       <= nxt_acc;
            carry_we_ff  <= nxt_carry_we;
            carry_ff     <= nxt_carry;
            file_we_ff   <= nxt_file_we;
            file_wd_ff   <= nxt_file_wd;
            irq_we_ff    <= nxt_irq_we;
            irq_ff       <= nxt_irq;
        end
    end

    // Every output except file_addr_o, ready_o and busy_o comes straight from a flip-flop, so the core never sees a decode glitch.
    assign stack_pop_o       = stack_pop_ff;
    assign pc_load_o         = pc_load_ff;
    assign program_counter_o = pc_ff;

    assign acc_we_o          = acc_we_ff;
    assign acc_o             = acc_ff;
    assign carry_we_o        = carry_we_ff;
    assign carry_o           = carry_ff;

    assign file_we_o         = file_we_ff;
    assign file_wdata_o      = file_wd_ff;
    assign irq_ctl_we_o      = irq_we_ff;
    assign irq_control_reg_o = irq_ff;
endmodule

// ### rre_exec_properties.sv
// Concurrent checks on the ports of the return and rotate execution unit.
`timescale 1ns/100ps
module rre_exec_props
    import rre_pkg::*;
#(
    parameter int PC_W = 15
)
(
    // Clock, reset and issue
    input wire logic            clk_i,
    input wire logic            rst_i,
    input wire logic            issue_i,
    input wire logic [13:0]     instr_i,
    input wire logic            ready_o,
    input wire logic            busy_o,
    // Stack and accumulator side
    input wire logic [PC_W-1:0] stack_top_entry_i,
    input wire logic            stack_pop_o,
    input wire logic            pc_load_o,
    input wire logic [PC_W-1:0] program_counter_o,
    input wire logic            carry_i,
    input wire logic            acc_we_o,
    input wire logic [7:0]      acc_o,
    input wire logic            carry_we_o,
    input wire logic            carry_o,
    // File and interrupt control side
    input wire logic [7:0]      file_rdata_i,
    input wire logic            file_we_o,
    input wire logic [7:0]      file_wdata_o,
    input wire logic [7:0]      irq_control_reg_i,
    input wire logic            irq_ctl_we_o,
    input wire logic [7:0]      irq_control_reg_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic go = issue_i && ready_o;
    // A return owns two cycles, so the second one must refuse and then free the unit.
    sequence s_pop;
        stack_pop_o && pc_load_o && program_counter_o == $past(stack_top_entry_i);
    endsequence
    sequence s_dead;
        busy_o && !ready_o ##1 ready_o && !stack_pop_o && !carry_we_o;
    endsequence
    a_irq_ret_pop: assert property (go && instr_i == 14'h0009 |=> s_pop ##0 s_dead)
        else $error("interrupt return did not pop into the program counter");
    a_irq_gie_set: assert property (go && instr_i == 14'h0009 |=> irq_ctl_we_o && !carry_we_o
        && irq_control_reg_o == ($past(irq_control_reg_i) | 8'h80)) else $error("enable bit not set");
    a_lit_ret_load: assert property (go && instr_i[13:8] == 6'h34 |=> s_pop ##0 acc_we_o
        && acc_o == $past(instr_i[7:0]) && !carry_we_o ##0 s_dead) else $error("literal return wrong");
    a_sub_ret_pop: assert property (go && instr_i == 14'h0008 |=> s_pop ##0 !acc_we_o
        && !irq_ctl_we_o && !carry_we_o ##0 s_dead) else $error("subroutine return wrong");
    a_rot_left_val: assert property (go && instr_i[13:8] == 6'h0D |=> carry_we_o && ready_o
        && carry_o == $past(file_rdata_i[7]) && (file_we_o ? file_wdata_o : acc_o)
        == {$past(file_rdata_i[6:0]), $past(carry_i)}) else $error("rotate left result wrong");
    a_rot_right_val: assert property (go && instr_i[13:8] == 6'h0C |=> carry_we_o
        && carry_o == $past(file_rdata_i[0]) && (file_we_o ? file_wdata_o : acc_o)
        == {$past(carry_i), $past(file_rdata_i[7:1])}) else $error("rotate right result wrong");
    a_rot_dest_sel: assert property (go && instr_i[13:9] == 5'h06 |=> file_we_o == $past(instr_i[7])
        && acc_we_o != $past(instr_i[7]) && !stack_pop_o) else $error("rotate destination wrong");
    a_busy_refuse: assert property (busy_o |=> !file_we_o && !acc_we_o && !irq_ctl_we_o)
        else $error("issue taken while busy");
endmodule

// ### tb_top.sv
// Self-checking bench for the return and rotate execution unit.
`timescale 1ns/100ps
module tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        issue_i = 1'b0;
    logic [13:0] instr_i = 14'h0000;
    logic [14:0] stack_top_entry_i = 15'h0000;
    logic [7:0]  acc_i = 8'h5A;
    logic        carry_i = 1'b0;
    logic [7:0]  file_rdata_i = 8'h00;
    logic [7:0]  irq_control_reg_i = 8'h15;
    logic        ready_o, busy_o, stack_pop_o, pc_load_o, acc_we_o, carry_we_o, carry_o, file_we_o, irq_ctl_we_o;
    logic [14:0] program_counter_o;
    logic [7:0]  acc_o, file_wdata_o, irq_control_reg_o;
    logic [6:0]  file_addr_o;
    int          fail_count = 0;
    int          samples_checked = 0;
    rre_exec #(.PC_W(15)) rre_exec_i (.clk_i, .rst_i, .issue_i, .instr_i, .ready_o, .busy_o,
        .stack_top_entry_i, .stack_pop_o, .pc_load_o, .program_counter_o, .acc_i, .carry_i, .acc_we_o,
        .acc_o, .carry_we_o, .carry_o, .file_addr_o, .file_rdata_i, .file_we_o, .file_wdata_o,
        .irq_control_reg_i, .irq_ctl_we_o, .irq_control_reg_o);
    always #50 clk_i = ~clk_i;
    task automatic stop_test;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic op(input logic [13:0] ins);
        issue_i = 1'b1;
        instr_i = ins;
        @(negedge clk_i);
    endtask
    // The rotate held over the dead cycle is refused there and taken once ready_o returns.
    task automatic ret(input logic [13:0] ins, input logic [14:0] top);
        stack_top_entry_i = top;
        op(ins);
        chk({stack_pop_o, pc_load_o, busy_o, ready_o, carry_we_o, file_we_o}, 6'b111000);
        chk(program_counter_o, top);
        chk(acc_we_o, ins[13:8] == 6'h34);
        chk(irq_ctl_we_o, ins == 14'h0009);
        if (ins[13:8] == 6'h34) chk(acc_o, ins[7:0]);
        if (ins == 14'h0009) chk(irq_control_reg_o, irq_control_reg_i | 8'h80);
        op(14'h0D80);
        chk({stack_pop_o, carry_we_o, file_we_o, acc_we_o, ready_o}, 5'b00001);
        op(14'h0D80);
        chk({carry_we_o, file_we_o, acc_we_o, ready_o}, 4'b1101);
        issue_i = 1'b0;
        @(negedge clk_i);
    endtask
    task automatic rot(input logic right, input logic d, input logic [7:0] x, input logic c);
        logic [7:0] exp;
        exp = right ? {c, x[7:1]} : {x[6:0], c};
        file_rdata_i = x;
        carry_i = c;
        op({5'b00110, !right, d, x[6:0]});
        chk(file_addr_o, x[6:0]);
        chk({carry_we_o, carry_o}, {1'b1, right ? x[0] : x[7]});
        chk(d ? file_wdata_o : acc_o, exp);
        chk({file_we_o, acc_we_o, ready_o, stack_pop_o}, {d, !d, 2'b10});
    endtask
    task automatic t_irq_ret;
        ret(14'h0009, 15'h7FFF);
    endtask
    task automatic t_lit_ret;
        ret(14'h3400, 15'h0001);
        ret(14'h34FF, 15'h4000);
    endtask
    task automatic t_sub_ret;
        ret(14'h0008, 15'h2AAA);
    endtask
    task automatic t_rot_burst;
        rot(1'b0, 1'b0, 8'hE6, 1'b0);
        rot(1'b0, 1'b1, 8'h81, 1'b1);
        rot(1'b1, 1'b0, 8'h01, 1'b1);
        rot(1'b1, 1'b1, 8'h7E, 1'b0);
        rot(1'b1, 1'b1, 8'hFF, 1'b1);
        rot(1'b0, 1'b0, 8'h00, 1'b0);
        issue_i = 1'b0;
        @(negedge clk_i);
    endtask
    // Opcodes outside the slice are dropped, and a reset in a return's dead cycle frees the unit.
    task automatic t_other_ops;
        op(14'h0000);
        chk({stack_pop_o, acc_we_o, carry_we_o, file_we_o, irq_ctl_we_o, ready_o}, 6'b000001);
        stack_top_entry_i = 15'h1234;
        op(14'h0008);
        rst_i = 1'b1;
        issue_i = 1'b0;
        @(negedge clk_i);
        rst_i = 1'b0;
        chk({stack_pop_o, pc_load_o, busy_o, ready_o}, 4'b0001);
        chk(program_counter_o, 15'h0000);
    endtask
    initial begin
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        chk(ready_o, 1'b1);
        t_irq_ret();
        t_lit_ret();
        t_sub_ret();
        t_rot_burst();
        t_other_ops();
        stop_test();
    end
    initial begin
        #2000000;
        fail_count++;
        stop_test();
    end
endmodule
bind rre_exec rre_exec_props #(.PC_W(PC_W)) props_i (.clk_i, .rst_i, .issue_i, .instr_i, .ready_o, .busy_o,
    .stack_top_entry_i, .stack_pop_o, .pc_load_o, .program_counter_o, .carry_i, .acc_we_o, .acc_o,
    .carry_we_o, .carry_o, .file_rdata_i, .file_we_o, .file_wdata_o, .irq_control_reg_i, .irq_ctl_we_o,
    .irq_control_reg_o);
